// ### rtl/nvcfg_top.v
`timescale 1ns/1ps
`include "nvcfg_defines.vh"
// Summary of operation
// RL1 - Config change only when forced-normal select and program permit both 1.
// RL2 - Forced-normal: watchdog off, all regulators on, transceiver active.
// RL3 - After factory restore, issue system reset and return to forced-normal.
// RL4 - Host first writes new configuration bytes to locations 73h and 74h.
// RL5 - Host then confirms by writing the correct checksum.
// RL6 - Valid checksum starts cell programming immediately.
// RL7 - Wrong checksum aborts; stored cells stay unchanged.
// RL8 - Successful programming ends with a system reset.
// RL9 - No valid read of cell contents while programming.
// RL10 - After programming, cells are write-protected until factory restore.
// RL11 - Program permit bit shows whether cells may be reprogrammed.
// RL12 - Rewrite tally counts reprogrammings, saturating at all ones.
// RL13 - Rewrite tally also counts each factory restore.
// RL14 - Saturated tally never blocks reprogramming.
// RL15 - Corrected-bit flag set on single-bit correction in cell contents.
// RL16 - Multi-bit failure: no restart after a programming cycle.
// RL17 - Host should read corrected-bit flag at end of production.
// RL18 - Checksum: 8-bit over 73h then 74h, poly 2Fh, init FFh, xor FFh.
// RL19 - Status at 70h: tally 7:2, corrected flag 1, permit 0.
// RL20 - Restore: reset pin low, bus lines pulled, held for restore delay.
// RL21 - Checksum write without permit or forced-normal is ignored.
// RL22 - Staged bytes without valid checksum never alter stored cells; bytes rewritten during programming are stored unchecked.
module nvcfg_top #(
    parameter RESTORE_CYC = `NVCFG_RESTORE_CYC
) (
    input  wire        i_ref_clk,
    input  wire        i_reset_out_low,
    input  wire [11:0] i_awaddr,
    input  wire        i_awvalid,
    output reg         o_awready,
    input  wire [31:0] i_wdata,
    input  wire [3:0]  i_wstrb,
    input  wire        i_wvalid,
    output reg         o_wready,
    output reg  [1:0]  o_bresp,
    output reg         o_bvalid,
    input  wire        i_bready,
    input  wire [11:0] i_araddr,
    input  wire        i_arvalid,
    output reg         o_arready,
    output reg  [31:0] o_rdata,
    output reg  [1:0]  o_rresp,
    output reg         o_rvalid,
    input  wire        i_rready,
    input  wire        i_restore_cond,
    input  wire        i_cell_err_single,
    input  wire        i_cell_err_multi,
    output reg         o_sys_reset,
    output reg         o_forced_normal,
    output reg         o_wdog_off,
    output reg         o_regs_on,
    output reg         o_xcvr_active,
    output reg  [7:0]  o_cfg0,
    output reg  [7:0]  o_cfg1
);

    //--------------------------------------------------------------
    // Constants and state
    //--------------------------------------------------------------
    localparam [1:0] ST_IDLE = 2'd0;
    localparam [1:0] ST_PROG = 2'd1;
    localparam [1:0] ST_RST  = 2'd2;
    localparam [1:0] ST_HALT = 2'd3;
    localparam [15:0] PROG_CYC = `NVCFG_PROG_CYC;
    localparam [15:0] REST_CYC = RESTORE_CYC;

    reg  [1:0]  state;
    reg  [15:0] prog_cnt;
    reg  [15:0] rest_cnt;
    reg         restored;
    reg  [7:0]  stage0;
    reg  [7:0]  stage1;
    reg  [7:0]  cksum;
    reg         fns;
    reg         permit;
    reg  [5:0]  tally;
    reg         corr_flag;
    reg  [11:0] aw_addr;
    reg  [31:0] w_data;
    reg  [3:0]  w_strb;
    reg         aw_full;
    reg         w_full;
    wire        do_write;
    wire [9:0]  w_idx;
    wire [9:0]  r_idx;
    wire        w_lane0;
    wire        ck_write;
    wire        ck_ok;
    wire        prog_open;
    wire        w_mapped;
    reg  [31:0] next_rdata;
    reg  [1:0]  next_rresp;

    //--------------------------------------------------------------
    // Checksum over the two staged bytes
    //--------------------------------------------------------------
    function [7:0] nvcfg_crc;
        input [7:0] b0;
        input [7:0] b1;
        reg   [7:0] c;
        reg   [7:0] d;
        integer     i;
        integer     j;
        begin
            c = `NVCFG_CRC_INIT;
            for (i = 0; i < 2; i = i + 1) begin
                d = ((i == 0) ? b0 : b1) ^ c;
                for (j = 0; j < 8; j = j + 1) begin
                    if (d[7])
                        d = {d[6:0], 1'b0} ^ `NVCFG_CRC_POLY;
                    else
                        d = {d[6:0], 1'b0};
                end
                c = d;
            end
            nvcfg_crc = c ^ `NVCFG_CRC_XOR;
        end
    endfunction

    //--------------------------------------------------------------
    // Write decode
    //--------------------------------------------------------------
    assign do_write  = aw_full && w_full && !o_bvalid;
    assign w_idx     = aw_addr[11:2];
    assign r_idx     = i_araddr[11:2];
    assign w_lane0   = w_strb[0];
    // Programming needs both forced-normal select and permit
    assign prog_open = fns && permit && (state == ST_IDLE); // [RL1]
    assign ck_write  = do_write && w_lane0
                       && (w_idx == {2'b00, `NVCFG_IDX_CKSUM});
    assign ck_ok     = (w_data[7:0] == nvcfg_crc(stage0, stage1)); // [RL18]
    assign w_mapped  = (w_idx == {2'b00, `NVCFG_IDX_STATUS})
                       || (w_idx == {2'b00, `NVCFG_IDX_CFG0})
                       || (w_idx == {2'b00, `NVCFG_IDX_CFG1})
                       || (w_idx == {2'b00, `NVCFG_IDX_CKSUM})
                       || (w_idx == {2'b00, `NVCFG_IDX_CTRL});

    //--------------------------------------------------------------
    // Write channel: address and data taken in either order
    //--------------------------------------------------------------
    always @(posedge i_ref_clk) begin
        if (!i_reset_out_low) begin
            aw_full   <= 1'b0;
            w_full    <= 1'b0;
            aw_addr   <= 12'h000;
            w_data    <= 32'h00000000;
            w_strb    <= 4'h0;
            o_awready <= 1'b1;
            o_wready  <= 1'b1;
            o_bvalid  <= 1'b0;
            o_bresp   <= `NVCFG_RESP_OKAY;
        end else begin
            if (i_awvalid && o_awready) begin
                aw_addr   <= i_awaddr;
                aw_full   <= 1'b1;
                o_awready <= 1'b0;
            end
            if (i_wvalid && o_wready) begin
                w_data   <= i_wdata;
                w_strb   <= i_wstrb;
                w_full   <= 1'b1;
                o_wready <= 1'b0;
            end
            if (do_write) begin
                aw_full  <= 1'b0;
                w_full   <= 1'b0;
                o_bvalid <= 1'b1;
                o_bresp  <= w_mapped ? `NVCFG_RESP_OKAY
                                     : `NVCFG_RESP_SLVERR;
            end
            if (o_bvalid && i_bready) begin
                o_bvalid  <= 1'b0;
                o_awready <= 1'b1;
                o_wready  <= 1'b1;
            end
        end
    end

    //--------------------------------------------------------------
    // Software-visible registers
    //--------------------------------------------------------------
    always @(posedge i_ref_clk) begin
        if (!i_reset_out_low) begin
            stage0 <= `NVCFG_CFG0_RST;
            stage1 <= `NVCFG_CFG1_RST;
            cksum  <= 8'h00;
            fns    <= 1'b1;
        end else if (do_write && w_lane0) begin
            // Staging only; cells are loaded by the sequencer
            if (w_idx == {2'b00, `NVCFG_IDX_CFG0})
                stage0 <= w_data[7:0]; // [RL4] [RL22]
            if (w_idx == {2'b00, `NVCFG_IDX_CFG1})
                stage1 <= w_data[7:0]; // [RL4] [RL22]
            if (w_idx == {2'b00, `NVCFG_IDX_CKSUM})
                cksum <= w_data[7:0]; // [RL5]
            if (w_idx == {2'b00, `NVCFG_IDX_CTRL})
                fns <= w_data[`NVCFG_CTRL_FNS];
        end
    end

    //--------------------------------------------------------------
    // Restore condition timer
    //--------------------------------------------------------------
    always @(posedge i_ref_clk) begin
        if (!i_reset_out_low) begin
            rest_cnt <= 16'h0000;
            restored <= 1'b0;
        end else if (!i_restore_cond) begin
            rest_cnt <= 16'h0000;
            restored <= 1'b0;
        end else if (rest_cnt < REST_CYC) begin
            rest_cnt <= rest_cnt + 16'h0001; // [RL20]
        end else if (state == ST_IDLE) begin
            restored <= 1'b1;
        end
    end

    //--------------------------------------------------------------
    // Programming sequencer and cell storage
    //--------------------------------------------------------------
    always @(posedge i_ref_clk) begin
        if (!i_reset_out_low) begin
            state       <= ST_IDLE;
            prog_cnt    <= 16'h0000;
            permit      <= 1'b1;
            tally       <= 6'h00;
            o_cfg0      <= `NVCFG_CFG0_RST;
            o_cfg1      <= `NVCFG_CFG1_RST;
            o_sys_reset <= 1'b0;
        end else begin
            o_sys_reset <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (rest_cnt == REST_CYC && !restored) begin
                        o_cfg0 <= `NVCFG_CFG0_RST;
                        o_cfg1 <= `NVCFG_CFG1_RST;
                        permit <= 1'b1; // [RL3] [RL11]
                        if (tally != `NVCFG_TALLY_MAX)
                            tally <= tally + 6'h01; // [RL13]
                        state <= ST_RST;
                    end else if (ck_write && prog_open) begin // [RL21]
                        // Tally saturation does not gate this [RL14]
                        if (ck_ok) begin
                            prog_cnt <= 16'h0000;
                            state    <= ST_PROG; // [RL6]
                        end // Mismatch leaves cells as they are [RL7]
                    end
                end
                ST_PROG: begin
                    if (prog_cnt == PROG_CYC - 16'h0001) begin
                        o_cfg0 <= stage0;
                        o_cfg1 <= stage1;
                        permit <= 1'b0; // [RL10] [RL11]
                        if (tally != `NVCFG_TALLY_MAX)
                            tally <= tally + 6'h01; // [RL12]
                        state <= i_cell_err_multi ? ST_HALT
                                                  : ST_RST; // [RL16]
                    end else begin
                        prog_cnt <= prog_cnt + 16'h0001;
                    end
                end
                ST_RST: begin
                    o_sys_reset <= 1'b1; // [RL8] [RL3]
                    state       <= ST_IDLE;
                end
                ST_HALT: begin
                    state <= ST_HALT; // [RL16]
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    //--------------------------------------------------------------
    // Corrected-bit flag, sticky until power-on reset
    //--------------------------------------------------------------
    always @(posedge i_ref_clk) begin
        if (!i_reset_out_low)
            corr_flag <= 1'b0;
        else if (i_cell_err_single)
            corr_flag <= 1'b1; // [RL15] [RL17]
    end

    //--------------------------------------------------------------
    // Forced-normal mode outputs
    //--------------------------------------------------------------
    always @(posedge i_ref_clk) begin
        if (!i_reset_out_low) begin
            o_forced_normal <= 1'b1;
            o_wdog_off      <= 1'b1;
            o_regs_on       <= 1'b1;
            o_xcvr_active   <= 1'b1;
        end else begin
            o_forced_normal <= permit;
            o_wdog_off      <= permit; // [RL2]
            o_regs_on       <= permit; // [RL2]
            o_xcvr_active   <= permit; // [RL2]
        end
    end

    //--------------------------------------------------------------
    // Read data mux
    //--------------------------------------------------------------
    always @* begin
        next_rdata = 32'h00000000;
        next_rresp = `NVCFG_RESP_OKAY;
        case (r_idx)
            {2'b00, `NVCFG_IDX_STATUS}:
                next_rdata[7:0] = {tally, corr_flag, permit}; // [RL19]
            {2'b00, `NVCFG_IDX_CFG0}: begin
                if (state == ST_PROG)
                    next_rresp = `NVCFG_RESP_SLVERR; // [RL9]
                else
                    next_rdata[7:0] = o_cfg0;
            end
            {2'b00, `NVCFG_IDX_CFG1}: begin
                if (state == ST_PROG)
                    next_rresp = `NVCFG_RESP_SLVERR; // [RL9]
                else
                    next_rdata[7:0] = o_cfg1;
            end
            {2'b00, `NVCFG_IDX_CKSUM}:
                next_rdata[7:0] = cksum;
            {2'b00, `NVCFG_IDX_CTRL}:
                next_rdata[`NVCFG_CTRL_FNS] = fns;
            default:
                next_rresp = `NVCFG_RESP_SLVERR;
        endcase
    end

    //--------------------------------------------------------------
    // Read channel
    //--------------------------------------------------------------
    always @(posedge i_ref_clk) begin
        if (!i_reset_out_low) begin
            o_arready <= 1'b1;
            o_rvalid  <= 1'b0;
            o_rdata   <= 32'h00000000;
            o_rresp   <= `NVCFG_RESP_OKAY;
        end else if (i_arvalid && o_arready) begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b1;
            o_rdata   <= next_rdata;
            o_rresp   <= next_rresp;
        end else if (o_rvalid && i_rready) begin
            o_rvalid  <= 1'b0;
            o_arready <= 1'b1;
        end
    end

endmodule // nvcfg_top

// ### rtl/nvcfg_defines.vh
`ifndef NVCFG_DEFINES_VH
`define NVCFG_DEFINES_VH

// Register indices; byte address is four times the index
`define NVCFG_IDX_STATUS   8'h70
`define NVCFG_IDX_CFG0     8'h73
`define NVCFG_IDX_CFG1     8'h74
`define NVCFG_IDX_CKSUM    8'h75
`define NVCFG_IDX_CTRL     8'h76

// Status and control field positions
`define NVCFG_ST_TALLY_HI  7
`define NVCFG_ST_TALLY_LO  2
`define NVCFG_ST_CORR      1
`define NVCFG_ST_PERMIT    0
`define NVCFG_CTRL_FNS     0

// Checksum parameters
`define NVCFG_CRC_POLY     8'h2f
`define NVCFG_CRC_INIT     8'hff
`define NVCFG_CRC_XOR      8'hff

// Reset values and tally limit
`define NVCFG_CFG0_RST     8'h00
`define NVCFG_CFG1_RST     8'h00
`define NVCFG_TALLY_MAX    6'h3f

// Timing
`define NVCFG_CLK_NS       10
`define NVCFG_PROG_NS      10000
`define NVCFG_RESTORE_NS   50000
`define NVCFG_PROG_CYC     ((`NVCFG_PROG_NS+`NVCFG_CLK_NS-1)/`NVCFG_CLK_NS)
`define NVCFG_RESTORE_CYC  ((`NVCFG_RESTORE_NS+`NVCFG_CLK_NS-1)/`NVCFG_CLK_NS)

// AXI responses
`define NVCFG_RESP_OKAY    2'b00
`define NVCFG_RESP_SLVERR  2'b10

`endif

// ### verif/nvcfg_top_assertions.sv
`timescale 1ns/1ps
// ---------------------------------------------
// Port checker for the cell programming block
// ---------------------------------------------
module nvcfg_chk (
    input wire        i_ref_clk,
    input wire        i_reset_out_low,
    input wire        i_awvalid,
    input wire        o_awready,
    input wire        i_wvalid,
    input wire        o_wready,
    input wire        o_bvalid,
    input wire        i_bready,
    input wire        i_arvalid,
    input wire        o_arready,
    input wire [31:0] o_rdata,
    input wire        o_rvalid,
    input wire        i_rready,
    input wire        i_restore_cond,
    input wire        i_cell_err_multi,
    input wire        o_sys_reset,
    input wire        o_forced_normal,
    input wire        o_wdog_off,
    input wire        o_regs_on,
    input wire        o_xcvr_active,
    input wire [7:0]  o_cfg0,
    input wire [7:0]  o_cfg1
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_out_low);

    a_write_answer: assert property (i_awvalid && o_awready && i_wvalid
        && o_wready |-> ##[1:2] o_bvalid) else $error("write answer late");
    a_read_answer: assert property (i_arvalid && o_arready |-> ##[1:2]
        o_rvalid) else $error("read answer late");
    a_rdata_hold: assert property (o_rvalid && !i_rready |=> o_rvalid
        && $stable(o_rdata)) else $error("read data not held");
    a_fn_group: assert property (o_wdog_off == o_forced_normal
        && o_regs_on == o_forced_normal && o_xcvr_active == o_forced_normal)
        else $error("forced normal outputs disagree");
    a_cfg_then_rst: assert property (($changed(o_cfg0)
        || $changed(o_cfg1)) && !i_cell_err_multi |-> ##[0:2] o_sys_reset)
        else $error("stored cells changed without system reset");
    a_rst_pulse: assert property (o_sys_reset |=> !o_sys_reset)
        else $error("system reset longer than one cycle");
    a_locked_cells: assert property (!o_forced_normal
        && !i_restore_cond |=> $stable(o_cfg0) && $stable(o_cfg1))
        else $error("protected cells changed");
    a_fn_change: assert property ($changed(o_forced_normal)
        |-> o_sys_reset || i_cell_err_multi)
        else $error("permit changed without reset");
    a_no_multi_rst: assert property ($past(i_cell_err_multi)
        && i_cell_err_multi && !$past(i_restore_cond) |-> !o_sys_reset)
        else $error("restart despite multi-bit failure");
endmodule // nvcfg_chk

bind nvcfg_top nvcfg_chk u_chk (.*);

// ### verif/nvcfg_host.sv
`timescale 1ns/1ps
// ---------------------------------------------
// Host microcontroller on the register bus
// ---------------------------------------------
module nvcfg_host (
    input  wire        i_ref_clk,
    output reg  [11:0] i_awaddr,
    output reg         i_awvalid,
    input  wire        o_awready,
    output reg  [31:0] i_wdata,
    output reg  [3:0]  i_wstrb,
    output reg         i_wvalid,
    input  wire        o_wready,
    input  wire        o_bvalid,
    output reg         i_bready,
    output reg  [11:0] i_araddr,
    output reg         i_arvalid,
    input  wire        o_arready,
    input  wire        o_rvalid,
    output reg         i_rready
);
    // Idle bus at time zero
    initial {i_awaddr, i_awvalid, i_wdata, i_wstrb, i_wvalid, i_bready,
        i_araddr, i_arvalid, i_rready} = 0;

    // Checksum over the two staged bytes, first byte first
    function automatic [7:0] crc8(input [7:0] b0, input [7:0] b1);
        reg [7:0] c;
        reg [15:0] d;
        integer   i;
        begin
            c = 8'hff;
            d = {b0, b1};
            for (i = 15; i >= 0; i = i - 1) begin
                c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h2f : 8'h00);
            end
            crc8 = c ^ 8'hff;
        end
    endfunction

    // One register write, address and data offered together
    task automatic wr(input [7:0] idx, input [7:0] d);
        begin
            @(posedge i_ref_clk);
            i_awaddr <= {2'b00, idx, 2'b00};
            i_wdata  <= {24'h0, d};
            i_wstrb  <= 4'hf;
            {i_awvalid, i_wvalid, i_bready} <= 3'b111;
            do begin
                @(posedge i_ref_clk);
                if (i_awvalid && o_awready) i_awvalid <= 1'b0;
                if (i_wvalid && o_wready) i_wvalid <= 1'b0;
            end while (!(o_bvalid && i_bready));
            i_bready <= 1'b0;
            i_wdata  <= ~i_wdata;
        end
    endtask

    // One register read
    task automatic rd(input [7:0] idx);
        begin
            @(posedge i_ref_clk);
            i_araddr <= {2'b00, idx, 2'b00};
            // Ready follows the accepted address, so one answer waits
            {i_arvalid, i_rready} <= 2'b10;
            do begin
                @(posedge i_ref_clk);
                if (i_arvalid && o_arready) i_arvalid <= 1'b0;
                if (!i_arvalid && !i_rready) i_rready <= 1'b1;
            end while (!(o_rvalid && i_rready));
            i_rready <= 1'b0;
            i_araddr <= ~i_araddr;
        end
    endtask
endmodule // nvcfg_host

// ### verif/nvcfg_top_bench.sv
`timescale 1ns/1ps
// ---------------------------------------------
// Self-checking bench
// ---------------------------------------------
module nvcfg_top_bench;
    localparam RCYC = 8;
    wire [11:0] i_awaddr, i_araddr;
    wire [31:0] i_wdata, o_rdata;
    wire [3:0]  i_wstrb;
    wire [1:0]  o_bresp, o_rresp;
    wire        i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
    wire        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    wire        o_sys_reset, o_forced_normal, o_wdog_off, o_regs_on;
    wire        o_xcvr_active;
    wire [7:0]  o_cfg0, o_cfg1;
    reg         i_ref_clk, i_reset_out_low, i_restore_cond;
    reg         i_cell_err_single, i_cell_err_multi, permit, flag;
    reg  [7:0]  s0, s1, e0, e1;
    reg  [33:0] rq[$];
    reg  [1:0]  bq[$];
    integer     err_count, tests_run, seed, tally, n;

    nvcfg_top #(.RESTORE_CYC(RCYC)) uut (.*);
    nvcfg_host host (.*);

    // Clock
    initial begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end

    task automatic chk(input [33:0] got, input [33:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("[ERR] %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask

    // Bus results against the oldest note
    always @(posedge i_ref_clk) begin
        if (o_rvalid && i_rready) chk({o_rresp, o_rdata}, rq.pop_front());
        if (o_bvalid && i_bready) chk({32'h0, o_bresp}, {32'h0, bq.pop_front()});
    end

    task automatic rd(input [7:0] idx, input [1:0] rs, input [7:0] d);
        begin
            rq.push_back({rs, 24'h0, d});
            host.rd(idx);
        end
    endtask

    task automatic wr(input [7:0] idx, input [7:0] d, input [1:0] rs);
        begin
            bq.push_back(rs);
            host.wr(idx, d);
        end
    endtask

    // Count cycles until a system reset pulse, or give up
    task automatic wait_rst(input integer lim, input exp);
        integer k;
        reg     seen;
        begin
            seen = 1'b0;
            for (k = 0; k < lim && !seen; k = k + 1) begin
                @(negedge i_ref_clk);
                seen = (o_sys_reset === 1'b1);
            end
            chk({33'h0, seen}, {33'h0, exp});
        end
    endtask

    // Stored cells, status and forced-normal outputs
    task automatic st;
        begin
            rd(8'h73, 2'b00, e0);
            rd(8'h74, 2'b00, e1);
            rd(8'h70, 2'b00, {tally[5:0], flag, permit});
            // Look at the outputs away from the launching edge
            @(negedge i_ref_clk);
            chk({o_cfg1, o_cfg0}, {e1, e0});
            chk({o_forced_normal, o_wdog_off, o_regs_on, o_xcvr_active},
                {4{permit}});
        end
    endtask

    // Mode 0 bad sum, 1 accepted, 2 ignored, 3 multi-bit halt
    task automatic prog(input integer mode);
        begin
            s0 = $random(seed);
            s1 = $random(seed);
            wr(8'h73, s0, 2'b00);
            wr(8'h74, s1, 2'b00);
            wr(8'h75, host.crc8(s0, s1) ^ {7'h0, mode == 0}, 2'b00);
            if (mode == 1) begin
                rd(8'h73, 2'b10, 8'h00);
                wait_rst(1100, 1'b1);
                {e0, e1} = {s0, s1};
                permit = 1'b0;
                tally = (tally < 63) ? tally + 1 : 63;
            end else begin
                wait_rst(1100, 1'b0);
            end
            if (mode != 3) st;
        end
    endtask

    task automatic restore;
        begin
            @(posedge i_ref_clk) i_restore_cond <= 1'b1;
            wait_rst(RCYC + 20, 1'b1);
            @(posedge i_ref_clk) i_restore_cond <= 1'b0;
            {e0, e1, permit} = 17'h1;
            tally = (tally < 63) ? tally + 1 : 63;
            st;
        end
    endtask

    task automatic close_out;
        begin
            $display("compares %0d errors %0d", tests_run, err_count);
            if (err_count == 0 && tests_run > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask

    // Main sequence
    initial begin
        {seed, err_count, tests_run, tally} = {32'd31344, 96'd0};
        {permit, flag, e0, e1} = 18'h20000;
        {i_reset_out_low, i_restore_cond, i_cell_err_single, i_cell_err_multi} = 0;
        repeat (20) @(posedge i_ref_clk);
        i_reset_out_low <= 1'b1;
        st;
        rd(8'h76, 2'b00, 8'h01);
        rd(8'h71, 2'b10, 8'h00);
        wr(8'h71, 8'h5a, 2'b10);
        prog(0);
        prog(1);
        prog(2);
        restore;
        wr(8'h76, 8'h00, 2'b00);
        prog(2);
        wr(8'h76, 8'h01, 2'b00);
        @(posedge i_ref_clk) i_cell_err_single <= 1'b1;
        @(posedge i_ref_clk) i_cell_err_single <= 1'b0;
        flag = 1'b1;
        for (n = 0; n < 33; n = n + 1) begin
            prog(1);
            restore;
        end
        prog(1);
        restore;
        @(posedge i_ref_clk) i_cell_err_multi <= 1'b1;
        prog(3);
        close_out;
    end

    // Watchdog against a hang
    initial begin
        #1000000;
        err_count = err_count + 1;
        close_out;
    end
endmodule // nvcfg_top_bench
